// *** design/tcd_pkg.sv ***
package tcd_pkg;
	localparam int NUM_CELLS = 4;
	localparam int DAC_W = 8;
	localparam int SETP_W = 12;
	localparam int NUM_PROFILES = 3;
	localparam int RATE_SEL_W = 2;
	localparam logic [7:0] DAC_RESET = 8'h80;
	localparam logic [DAC_W-1:0] DAC_MAX = 8'hFF;
	localparam logic [DAC_W-1:0] DAC_MIN = 8'h00;
	localparam logic [SETP_W-1:0] SETP_RESET = 12'h000;
	localparam int CLOCK_HZ = 50000000;
	localparam int RATE0_US = 860;
	localparam int RATE1_US = 1720;
	localparam int RATE2_US = 13800;
	localparam int RATE3_US = 27600;
	localparam int RATE0_CYC = RATE0_US * (CLOCK_HZ / 1000000);
	localparam int RATE1_CYC = RATE1_US * (CLOCK_HZ / 1000000);
	localparam int RATE2_CYC = RATE2_US * (CLOCK_HZ / 1000000);
	localparam int RATE3_CYC = RATE3_US * (CLOCK_HZ / 1000000);
	localparam int TICK_W = 21;

	typedef enum logic {
		TCD_MODE_CLOSED_LOOP,
		TCD_MODE_FIXED_CODE
	} tcd_mode_e;

	typedef struct packed {
		logic profileSelBit0;
		logic profileSelBit1;
		logic closedLoopTrimEn;
		logic trimOutEn;
	} tcd_ctrl_s;

	typedef struct packed {
		logic [DAC_W-1:0] dacCode;
		logic outEn;
	} tcd_dac_s;
endpackage

// *** design/trim_cell_dac_control.sv ***
// Overview of operation
// - Four independent trim cells, each controlling its own DAC register.
// - Each cell runs fixed-code or closed-loop mode and drives an 8-bit DAC.
// - With no mode chosen, a cell defaults to closed-loop mode.
// - Fixed-code mode applies the selected stored code directly to the DAC register.
// - Fixed-code mode holds three stored 8-bit codes, profiles 0 to 2.
// - Fixed-code mode reloads the DAC register when the selected profile changes; select 3 counts as profile 2.
// - Profile 0 DAC code is writable at run time; others are fixed.
// - Writes to profile 0 DAC code are blocked while write protect is set.
// - Closed-loop mode holds three stored 12-bit setpoints, profiles 0 to 2.
// - Closed-loop mode copies the selected setpoint when the selected profile changes; select 3 counts as profile 2.
// - Profile 0 setpoint is writable at run time unless write protect is set.
// - Closed loop compares setpoint with the monitored voltage and adjusts the DAC.
// - Closed-loop trimming happens only while closed_loop_trim_en is 1.
// - The DAC output is driven only while trim_out_en is 1.
// - Each cell has its own two profile select signals.
// - Stored configuration mode decides how the DAC register is updated.
// - Closed loop disabled keeps the last DAC value; reset value is 80h.
// - At reset output off, loop off, DAC 80h, setpoint 000h; the next cycle loads profile 0 setpoint and, in fixed-code mode, the DAC code.
// - Each update steps the DAC by polarity and comparison sign, none when equal; the DAC does not step down from 00h or up from FFh.
// - Update interval is one of four shared settings from 860 us to 27.6 ms.
module trim_cell_dac_control
	import tcd_pkg::*;
#(
	parameter int CELLS = NUM_CELLS,
	parameter int UPDATE_CYC0 = RATE0_CYC,
	parameter int UPDATE_CYC1 = RATE1_CYC,
	parameter int UPDATE_CYC2 = RATE2_CYC,
	parameter int UPDATE_CYC3 = RATE3_CYC
) (
	// Clock and reset.
	input wire logic clock,
	input wire logic reset_n,
	// Expander control link, one group per cell.
	input wire tcd_ctrl_s [CELLS-1:0] linkCtrl,
	// Stored configuration.
	input wire logic [CELLS-1:0] cfgFixedCodeMode,
	input wire logic [CELLS-1:0] cfgPolarityInv,
	input wire logic [RATE_SEL_W-1:0] cfgUpdateRate,
	input wire logic cfgWriteProtect,
	input wire logic [CELLS-1:0][NUM_PROFILES-1:0][DAC_W-1:0] cfgDacCode,
	input wire logic [CELLS-1:0][NUM_PROFILES-1:0][SETP_W-1:0] cfgSetpoint,
	// Run-time profile 0 writes.
	input wire logic [CELLS-1:0] wrDacCodeP0,
	input wire logic [CELLS-1:0] wrSetpointP0,
	input wire logic [DAC_W-1:0] wrDacData,
	input wire logic [SETP_W-1:0] wrSetpointData,
	// Digitised voltage monitor inputs.
	input wire logic [CELLS-1:0][SETP_W-1:0] monitorVoltage,
	// DAC and setpoint outputs.
	output tcd_dac_s [CELLS-1:0] dacOut,
	output logic [CELLS-1:0][SETP_W-1:0] setpointOut
);

	// Elaboration checks on the parameters that the logic can serve.
	if (CELLS < 1 || CELLS > NUM_CELLS) begin : g_badCells
		$error("CELLS out of range");
	end
	if (UPDATE_CYC0 < 2 || UPDATE_CYC1 < 2 || UPDATE_CYC2 < 2 || UPDATE_CYC3 < 2 ||
		UPDATE_CYC0 >= (1 << TICK_W) || UPDATE_CYC1 >= (1 << TICK_W) ||
		UPDATE_CYC2 >= (1 << TICK_W) || UPDATE_CYC3 >= (1 << TICK_W)) begin : g_badRate
		$error("update interval out of range");
	end

	function automatic logic [1:0] profileIndex(input logic b0, input logic b1);
		logic [1:0] v;
		v = {b1, b0};
		return (v == 2'h3) ? 2'h2 : v;
	endfunction

	// Pin synchronisers for the link inputs.
	tcd_ctrl_s [CELLS-1:0] sync1_q, sync2_q, sync3_q, ctrl_q;
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			sync1_q <= '0;
			sync2_q <= '0;
			sync3_q <= '0;
		end else begin
			sync1_q <= linkCtrl;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			ctrl_q <= '0;
		end else begin
			for (int c = 0; c < CELLS; c++) begin
				if (sync2_q[c] == sync3_q[c]) begin
					ctrl_q[c] <= sync3_q[c];
				end
			end
		end
	end

	// Shared update tick.
	logic [TICK_W-1:0] tickCnt_q, tickLimit;
	logic tick;
	always_comb begin
		case (cfgUpdateRate)
			2'h0: tickLimit = TICK_W'(UPDATE_CYC0 - 1);
			2'h1: tickLimit = TICK_W'(UPDATE_CYC1 - 1);
			2'h2: tickLimit = TICK_W'(UPDATE_CYC2 - 1);
			default: tickLimit = TICK_W'(UPDATE_CYC3 - 1);
		endcase
	end
	assign tick = (tickCnt_q >= tickLimit);
	always_ff @(posedge clock) begin
		if (!reset_n || tick) begin
			tickCnt_q <= '0;
		end else begin
			tickCnt_q <= tickCnt_q + TICK_W'(1);
		end
	end

	// Run-time profile 0 storage.
	logic [CELLS-1:0][DAC_W-1:0] dacP0_q;
	logic [CELLS-1:0][SETP_W-1:0] setP0_q;
	logic [CELLS-1:0] loaded_q;
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			dacP0_q <= '0;
			setP0_q <= '0;
			loaded_q <= '0;
		end else begin
			for (int c = 0; c < CELLS; c++) begin
				loaded_q[c] <= 1'b1;
				if (!loaded_q[c]) begin
					dacP0_q[c] <= cfgDacCode[c][0];
					setP0_q[c] <= cfgSetpoint[c][0];
				end else begin
					if (wrDacCodeP0[c] && !cfgWriteProtect) begin
						dacP0_q[c] <= wrDacData;
					end
					if (wrSetpointP0[c] && !cfgWriteProtect) begin
						setP0_q[c] <= wrSetpointData;
					end
				end
			end
		end
	end

	// Profile select change detection.
	logic [CELLS-1:0][1:0] selPrev_q;
	logic [CELLS-1:0] selChg;
	always_comb begin
		for (int c = 0; c < CELLS; c++) begin
			selChg[c] = (profileIndex(ctrl_q[c].profileSelBit0, ctrl_q[c].profileSelBit1) != selPrev_q[c]);
		end
	end
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			selPrev_q <= '0;
		end else begin
			for (int c = 0; c < CELLS; c++) begin
				selPrev_q[c] <= profileIndex(ctrl_q[c].profileSelBit0, ctrl_q[c].profileSelBit1);
			end
		end
	end

	function automatic logic [DAC_W-1:0] pickDac(input int c, input logic [1:0] p);
		return (p == 2'h0) ? dacP0_q[c] : cfgDacCode[c][p];
	endfunction
	function automatic logic [SETP_W-1:0] pickSet(input int c, input logic [1:0] p);
		return (p == 2'h0) ? setP0_q[c] : cfgSetpoint[c][p];
	endfunction

	// Voltage setpoint registers.
	logic [CELLS-1:0][SETP_W-1:0] setpoint_q;
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			setpoint_q <= '0;
		end else begin
			for (int c = 0; c < CELLS; c++) begin
				if (!loaded_q[c]) begin
					setpoint_q[c] <= cfgSetpoint[c][0];
				end else if (selChg[c]) begin
					setpoint_q[c] <= pickSet(c, profileIndex(ctrl_q[c].profileSelBit0,
						ctrl_q[c].profileSelBit1));
				end
			end
		end
	end

	// DAC registers.
	tcd_mode_e [CELLS-1:0] mode;
	logic [CELLS-1:0][DAC_W-1:0] dac_q;
	logic [CELLS-1:0] outEn_q;
	always_comb begin
		for (int c = 0; c < CELLS; c++) begin
			mode[c] = cfgFixedCodeMode[c] ? TCD_MODE_FIXED_CODE : TCD_MODE_CLOSED_LOOP;
		end
	end
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			dac_q <= {CELLS{DAC_RESET}};
		end else begin
			for (int c = 0; c < CELLS; c++) begin
				case (mode[c])
					TCD_MODE_FIXED_CODE: begin
						if (!loaded_q[c]) begin
							dac_q[c] <= cfgDacCode[c][0];
						end else if (selChg[c]) begin
							dac_q[c] <= pickDac(c, profileIndex(ctrl_q[c].profileSelBit0,
								ctrl_q[c].profileSelBit1));
						end
					end
					TCD_MODE_CLOSED_LOOP: begin
						if (loaded_q[c] && tick && ctrl_q[c].closedLoopTrimEn) begin
							if (setpoint_q[c] != monitorVoltage[c]) begin
								if ((setpoint_q[c] > monitorVoltage[c]) ^ cfgPolarityInv[c]) begin
									if (dac_q[c] != DAC_MAX) dac_q[c] <= dac_q[c] + 8'h01;
								end else begin
									if (dac_q[c] != DAC_MIN) dac_q[c] <= dac_q[c] - 8'h01;
								end
							end
						end
					end
					default: dac_q[c] <= dac_q[c];
				endcase
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			outEn_q <= '0;
		end else begin
			for (int c = 0; c < CELLS; c++) begin
				outEn_q[c] <= ctrl_q[c].trimOutEn;
			end
		end
	end

	always_comb begin
		for (int c = 0; c < CELLS; c++) begin
			dacOut[c].dacCode = dac_q[c];
			dacOut[c].outEn = outEn_q[c];
			setpointOut[c] = setpoint_q[c];
		end
	end

	// Assertions, one set per cell, plus one shared update tick check.
	for (genvar g = 0; g < CELLS; g++) begin : g_chk
		property p_protect;
			@(posedge clock) disable iff (!reset_n)
			(cfgWriteProtect && loaded_q[g]) |=> $stable(dacP0_q[g]) && $stable(setP0_q[g]);
		endproperty
		a_protect: assert property (p_protect) else $error("protected profile 0 changed");

		property p_outen;
			@(posedge clock) disable iff (!reset_n)
			outEn_q[g] == $past(ctrl_q[g].trimOutEn);
		endproperty
		a_outen: assert property (p_outen) else $error("output enable mismatch");

		property p_hold;
			@(posedge clock) disable iff (!reset_n)
			(mode[g] == TCD_MODE_CLOSED_LOOP && !ctrl_q[g].closedLoopTrimEn) |=> $stable(dac_q[g]);
		endproperty
		a_hold: assert property (p_hold) else $error("dac moved with loop off");

		property p_equal;
			@(posedge clock) disable iff (!reset_n)
			(mode[g] == TCD_MODE_CLOSED_LOOP && setpoint_q[g] == monitorVoltage[g]) |=> $stable(dac_q[g]);
		endproperty
		a_equal: assert property (p_equal) else $error("dac moved on equal compare");

		property p_step;
			@(posedge clock) disable iff (!reset_n)
			(mode[g] == TCD_MODE_CLOSED_LOOP && loaded_q[g] && tick && ctrl_q[g].closedLoopTrimEn
				&& !cfgPolarityInv[g] && setpoint_q[g] > monitorVoltage[g] && dac_q[g] != DAC_MAX)
				|=> dac_q[g] == $past(dac_q[g]) + 8'h01;
		endproperty
		a_step: assert property (p_step) else $error("closed loop did not step up");

		property p_down;
			@(posedge clock) disable iff (!reset_n)
			(mode[g] == TCD_MODE_CLOSED_LOOP && loaded_q[g] && tick && ctrl_q[g].closedLoopTrimEn
				&& !cfgPolarityInv[g] && setpoint_q[g] < monitorVoltage[g] && dac_q[g] != DAC_MIN)
				|=> dac_q[g] == $past(dac_q[g]) - 8'h01;
		endproperty
		a_down: assert property (p_down) else $error("closed loop did not step down");

		property p_sat;
			@(posedge clock) disable iff (!reset_n)
			(mode[g] == TCD_MODE_CLOSED_LOOP && dac_q[g] == DAC_MAX) |=> dac_q[g] != DAC_MIN;
		endproperty
		a_sat: assert property (p_sat) else $error("dac wrapped past full scale");

		property p_fixed;
			@(posedge clock) disable iff (!reset_n)
			(mode[g] == TCD_MODE_FIXED_CODE && loaded_q[g] && selChg[g] && selPrev_q[g] != 2'h0
				&& profileIndex(ctrl_q[g].profileSelBit0, ctrl_q[g].profileSelBit1) == 2'h2)
				|=> dac_q[g] == cfgDacCode[g][2];
		endproperty
		a_fixed: assert property (p_fixed) else $error("fixed code not loaded");

		property p_fixload;
			@(posedge clock) disable iff (!reset_n)
			(mode[g] == TCD_MODE_FIXED_CODE && !loaded_q[g]) |=> dac_q[g] == $past(cfgDacCode[g][0]);
		endproperty
		a_fixload: assert property (p_fixload) else $error("profile 0 code not loaded at start");

		property p_setload;
			@(posedge clock) disable iff (!reset_n)
			!loaded_q[g] |=> setpoint_q[g] == $past(cfgSetpoint[g][0]);
		endproperty
		a_setload: assert property (p_setload) else $error("profile 0 setpoint not loaded at start");

		property p_setcopy;
			@(posedge clock) disable iff (!reset_n)
			(loaded_q[g] && selChg[g] && profileIndex(ctrl_q[g].profileSelBit0, ctrl_q[g].profileSelBit1) == 2'h1)
				|=> setpoint_q[g] == cfgSetpoint[g][1];
		endproperty
		a_setcopy: assert property (p_setcopy) else $error("setpoint not copied");

		property p_sync;
			@(posedge clock) disable iff (!reset_n)
			!$stable(ctrl_q[g]) |-> $past(sync2_q[g] == sync3_q[g]);
		endproperty
		a_sync: assert property (p_sync) else $error("link change taken before it settled");

		c_step: cover property (@(posedge clock) disable iff (!reset_n) tick && ctrl_q[g].closedLoopTrimEn);
		c_sel: cover property (@(posedge clock) disable iff (!reset_n) selChg[g]);
		c_wr: cover property (@(posedge clock) disable iff (!reset_n) wrDacCodeP0[g] && !cfgWriteProtect);
		c_oe: cover property (@(posedge clock) disable iff (!reset_n) outEn_q[g]);
	end

	property p_tick;
		@(posedge clock) disable iff (!reset_n)
		tick |=> !tick;
	endproperty
	a_tick: assert property (p_tick) else $error("update tick too frequent");

endmodule // trim_cell_dac_control

// *** tb/tcd_link_model.sv ***
module tcd_link_model
	import tcd_pkg::*;
(
	// Clock.
	input wire logic clock,
	// Control link toward the cells.
	output tcd_ctrl_s [NUM_CELLS-1:0] linkCtrl
);
	timeunit 1ns;
	timeprecision 1ps;

	initial linkCtrl = '0;

	// Drives one cell's select, loop enable and output enable just after an edge.
	task automatic setCell(input int c, input logic [1:0] sel, input logic cle, input logic oe);
		@(posedge clock);
		linkCtrl[c].profileSelBit0 <= sel[0];
		linkCtrl[c].profileSelBit1 <= sel[1];
		linkCtrl[c].closedLoopTrimEn <= cle;
		linkCtrl[c].trimOutEn <= oe;
	endtask
endmodule // tcd_link_model

// *** tb/tb.sv ***
`define CHK(what, exp, got) begin compares++; if ((got) !== (exp)) begin err_total++; \
	$display("CHECK FAILED %s expected %0h seen %0h", what, exp, got); end end
module tb;
	import tcd_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 1'b0;
	logic resetN = 1'b0;
	tcd_ctrl_s [NUM_CELLS-1:0] linkCtrl;
	logic [NUM_CELLS-1:0] cfgFixedCodeMode = 4'h3;
	logic [NUM_CELLS-1:0] cfgPolarityInv = 4'h8;
	logic [RATE_SEL_W-1:0] cfgUpdateRate = 2'h0;
	logic cfgWriteProtect = 1'b1;
	logic [NUM_CELLS-1:0][NUM_PROFILES-1:0][DAC_W-1:0] cfgDacCode;
	logic [NUM_CELLS-1:0][NUM_PROFILES-1:0][SETP_W-1:0] cfgSetpoint;
	logic [NUM_CELLS-1:0] wrDacCodeP0 = 4'h0;
	logic [NUM_CELLS-1:0] wrSetpointP0 = 4'h0;
	logic [DAC_W-1:0] wrDacData = 8'h00;
	logic [SETP_W-1:0] wrSetpointData = 12'h000;
	logic [NUM_CELLS-1:0][SETP_W-1:0] monitorVoltage;
	tcd_dac_s [NUM_CELLS-1:0] dacOut;
	logic [NUM_CELLS-1:0][SETP_W-1:0] setpointOut;
	int err_total = 0;
	int compares = 0;
	logic [DAC_W-1:0] held;

	always #10 clock = ~clock;

	tcd_link_model link (.clock(clock), .linkCtrl(linkCtrl));

	trim_cell_dac_control #(.CELLS(NUM_CELLS), .UPDATE_CYC0(8), .UPDATE_CYC1(16), .UPDATE_CYC2(32),
		.UPDATE_CYC3(64)) uut (.clock(clock), .reset_n(resetN), .linkCtrl(linkCtrl),
		.cfgFixedCodeMode(cfgFixedCodeMode), .cfgPolarityInv(cfgPolarityInv), .cfgUpdateRate(cfgUpdateRate),
		.cfgWriteProtect(cfgWriteProtect), .cfgDacCode(cfgDacCode), .cfgSetpoint(cfgSetpoint),
		.wrDacCodeP0(wrDacCodeP0), .wrSetpointP0(wrSetpointP0), .wrDacData(wrDacData),
		.wrSetpointData(wrSetpointData), .monitorVoltage(monitorVoltage), .dacOut(dacOut),
		.setpointOut(setpointOut));

	function automatic logic [DAC_W-1:0] code(input int c, input int p);
		return 8'(16 * c + p + 1);
	endfunction

	function automatic logic [SETP_W-1:0] setp(input int c, input int p);
		return 12'(256 * c + 16 * p + 64);
	endfunction

	// Lets a link change pass the synchroniser and reach the outputs.
	task automatic settle;
		repeat (8) @(posedge clock);
		#1;
	endtask

	// Issues one profile 0 write pulse to the cells in the mask.
	task automatic wrP0(input logic [3:0] mask, input logic [7:0] d, input logic [11:0] s);
		@(posedge clock);
		wrDacCodeP0 <= mask;
		wrSetpointP0 <= mask;
		wrDacData <= d;
		wrSetpointData <= s;
		@(posedge clock);
		wrDacCodeP0 <= 4'h0;
		wrSetpointP0 <= 4'h0;
	endtask

	// Selects a profile on fixed cell 0 and closed-loop cell 2, then checks both.
	task automatic pick(input logic [1:0] sel, input logic [7:0] d0, input logic [11:0] s2);
		link.setCell(0, sel, 1'b0, 1'b0);
		link.setCell(2, sel, 1'b0, 1'b0);
		settle();
		`CHK("dac0", d0, dacOut[0].dacCode)
		`CHK("setp2", s2, setpointOut[2])
		`CHK("dac1", code(1, 0), dacOut[1].dacCode)
	endtask

	task automatic summarize;
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	initial begin
		for (int c = 0; c < NUM_CELLS; c++) begin
			monitorVoltage[c] = setp(c, 0);
			for (int p = 0; p < NUM_PROFILES; p++) begin
				cfgDacCode[c][p] = code(c, p);
				cfgSetpoint[c][p] = setp(c, p);
			end
		end
		@(posedge clock);
		#1;
		`CHK("rstDac", DAC_RESET, dacOut[0].dacCode)
		`CHK("rstOe", 1'b0, dacOut[0].outEn)
		`CHK("rstSetp", SETP_RESET, setpointOut[0])
		@(posedge clock);
		resetN <= 1'b1;
		settle();
		for (int c = 0; c < NUM_CELLS; c++) begin
			`CHK("upDac", (c < 2) ? code(c, 0) : DAC_RESET, dacOut[c].dacCode)
			`CHK("upSetp", setp(c, 0), setpointOut[c])
			`CHK("upOe", 1'b0, dacOut[c].outEn)
		end
		for (int s = 1; s <= 4; s++) begin
			pick(2'(s), code(0, (s % 4 == 3) ? 2 : s % 4), setp(2, (s % 4 == 3) ? 2 : s % 4));
		end
		wrP0(4'h5, 8'hA5, 12'hABC);
		pick(2'h1, code(0, 1), setp(2, 1));
		pick(2'h0, code(0, 0), setp(2, 0));
		@(posedge clock);
		cfgWriteProtect <= 1'b0;
		wrP0(4'h5, 8'hA5, 12'hABC);
		pick(2'h1, code(0, 1), setp(2, 1));
		pick(2'h0, 8'hA5, 12'hABC);
		@(posedge clock);
		monitorVoltage[2] <= 12'h23F;
		monitorVoltage[3] <= setp(3, 0) - 12'h001;
		link.setCell(2, 2'h0, 1'b0, 1'b1);
		link.setCell(3, 2'h0, 1'b0, 1'b1);
		settle();
		`CHK("oe2", 1'b1, dacOut[2].outEn)
		`CHK("oe0", 1'b0, dacOut[0].outEn)
		repeat (40) @(posedge clock);
		#1;
		`CHK("hold2", DAC_RESET, dacOut[2].dacCode)
		link.setCell(2, 2'h0, 1'b1, 1'b1);
		link.setCell(3, 2'h0, 1'b1, 1'b1);
		repeat (60) @(posedge clock);
		#1;
		`CHK("up2", 1'b1, dacOut[2].dacCode > DAC_RESET)
		`CHK("down3", 1'b1, dacOut[3].dacCode < DAC_RESET)
		@(posedge clock);
		monitorVoltage[2] <= 12'hABC;
		settle();
		held = dacOut[2].dacCode;
		repeat (40) @(posedge clock);
		#1;
		`CHK("eq2", held, dacOut[2].dacCode)
		@(posedge clock);
		cfgUpdateRate <= 2'h3;
		monitorVoltage[2] <= 12'h000;
		#1;
		held = dacOut[2].dacCode;
		repeat (130) @(posedge clock);
		#1;
		`CHK("rate3", 1'b1, (8'(dacOut[2].dacCode - held) inside {8'h02, 8'h03}))
		summarize();
	end

	initial begin
		repeat (5000) @(posedge clock);
		err_total++;
		summarize();
	end
endmodule // tb
